// ==== shared/intc_map.svh ====
// Purpose: register offsets, field positions and fixed values of the
//          interrupt priority controller
// Assumes: word-addressed plain register port, 16-bit data
// Notes:   definitions only
`ifndef INTC_MAP_SVH
`define INTC_MAP_SVH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define USR_NUM        8
`define TRAP_NUM       4
`define CAND_NUM       12
`define STACK_DEPTH    16
`define STACK_PW       5
`define TDIS_W         14

// ----------------------------------------------------------------------
// register offsets (word index)
// ----------------------------------------------------------------------
`define ADR_PRI_EXT2   5'h00
`define ADR_PRI_SERR   5'h01
`define ADR_PRI_LAST   5'h07
`define ADR_FLAG       5'h08
`define ADR_ENABLE     5'h09
`define ADR_CTRL_ONE   5'h0a
`define ADR_STATUS     5'h0b

// ----------------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------------
`define PRI_MSB        6
`define PRI_LSB        4
`define PRI_RESET      3'h4
`define PRI_OFF        3'h0
`define NEST_BIT       15
`define TRAP_MSB       3
`define LVL_MSB        11
`define LVL_LSB        8
`define VEC_MSB        6
`define VEC_LSB        0
`define LEVEL_ZERO     4'h0
`define LEVEL_USER_TOP 4'h7
`define TRAP_TOP_LEVEL 4'hf
`define USER_CODE_BASE 7'h04
`define WORD_ZERO      16'h0000

`endif

// ==== shared/intc_pkg.sv ====
// Purpose: shared types of the interrupt priority controller
// Assumes: nothing
// Notes:   constants live in intc_map.svh
`default_nettype none

package intc_pkg;
  typedef logic [3:0]  level_type;
  typedef logic [2:0]  prio_type;
  typedef logic [6:0]  vec_code_type;
  typedef logic [15:0] word_type;
  typedef logic [4:0]  addr_type;
  typedef logic [7:0]  slb_type;
  typedef logic [27:0] ctx_type;
  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_PRI    = 3'b001,
    SEL_FLAG   = 3'b010,
    SEL_ENABLE = 3'b011,
    SEL_CTRL   = 3'b100,
    SEL_STATUS = 3'b101
  } reg_sel_type;
endpackage : intc_pkg

`default_nettype wire

// ==== hdl/level_picker.sv ====
// Purpose: choose the highest-level candidate among pending sources
// Assumes: candidate index order equals vector code order
// Notes:   purely combinational
`default_nettype none
`include "intc_map.svh"

module level_picker (
  input  wire logic                cand_in [`CAND_NUM],
  input  wire intc_pkg::level_type lvl_in  [`CAND_NUM],
  output logic                     found_out,
  output intc_pkg::level_type      level_out,
  output logic [3:0]               idx_out
);
  import intc_pkg::*;

  always_comb begin
    found_out = 1'b0;
    level_out = `LEVEL_ZERO;
    idx_out   = 4'h0;
    for (int k = 0; k < `CAND_NUM; k++) begin
      // strict compare: on a tie the lower code already held wins
      if (cand_in[k]
          && (!found_out || lvl_in[k] > level_out)) begin
        found_out = 1'b1;
        level_out = lvl_in[k];
        idx_out   = 4'(k);
      end
    end
  end
endmodule : level_picker

`default_nettype wire

// ==== hdl/ctx_stack.sv ====
// Purpose: saved context (pc, status low byte, old level) per nesting
// Assumes: caller never pushes when full nor pops when empty
// Notes:   entries themselves are memory, only the pointer is reset
`default_nettype none
`include "intc_map.svh"

module ctx_stack (
  input  wire logic              core_clk_in,
  input  wire logic              rstn_in,
  input  wire logic              push_in,
  input  wire logic              pop_in,
  input  wire intc_pkg::ctx_type data_in,
  output intc_pkg::ctx_type      top_out,
  output logic                   empty_out,
  output logic                   full_out
);
  import intc_pkg::*;

  ctx_type               mem [`STACK_DEPTH];
  logic [`STACK_PW-1:0]  ptr_r;

  assign empty_out = (ptr_r == '0);
  assign full_out  = (ptr_r == `STACK_PW'(`STACK_DEPTH));
  assign top_out   = mem[4'(ptr_r - 1'b1)];

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ptr_r <= '0;
    end else if (push_in && !full_out) begin
      ptr_r <= ptr_r + 1'b1;
    end else if (pop_in && !empty_out) begin
      ptr_r <= ptr_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (push_in && !full_out) begin
      mem[4'(ptr_r)] <= data_in;
    end
  end
endmodule : ctx_stack

`default_nettype wire

// ==== hdl/intc_core.sv ====
// Purpose: interrupt priority, flag/enable gating and level tracking
// Assumes: peripheral events and core handshakes are on core_clk_in
// Notes:   ext_pin2_in is an asynchronous pin, synchronised here
`default_nettype none
`include "intc_map.svh"

module intc_core (
  input  wire logic                   core_clk_in,
  input  wire logic                   rstn_in,
  input  wire intc_pkg::addr_type     reg_addr_in,
  input  wire intc_pkg::word_type     reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output intc_pkg::word_type          reg_rdata_out,
  input  wire logic [`USR_NUM-1:0]    src_event_in,
  input  wire logic                   ext_pin2_in,
  input  wire logic [`TRAP_NUM-1:0]   trap_event_in,
  input  wire logic                   irq_ack_in,
  input  wire intc_pkg::word_type     pc_in,
  input  wire intc_pkg::slb_type      slb_in,
  input  wire logic                   ret_in,
  input  wire logic                   level_wr_in,
  input  wire intc_pkg::level_type    level_in,
  input  wire logic                   tdis_start_in,
  input  wire logic [`TDIS_W-1:0]     tdis_count_in,
  output logic                        irq_req_out,
  output intc_pkg::vec_code_type      irq_vector_out,
  output intc_pkg::level_type         irq_level_out,
  output intc_pkg::level_type         cpu_level_out,
  output logic                        tdis_active_out,
  output logic                        restore_valid_out,
  output intc_pkg::word_type          restore_pc_out,
  output intc_pkg::slb_type           restore_slb_out
);
  import intc_pkg::*;

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  prio_type              pri_r [`USR_NUM];
  logic [`USR_NUM-1:0]   user_flag_r;
  logic [`USR_NUM-1:0]   en_r;
  logic [`TRAP_NUM-1:0]  trap_flag_r;
  logic                  nest_dis_r;
  level_type             cpu_level_r;
  logic [`TDIS_W-1:0]    tdis_cnt_r;
  logic [2:0]            pin_sync_r;
  logic                  irq_req_r;
  vec_code_type          irq_vec_r;
  level_type             irq_lvl_r;
  word_type              rdata_r;
  logic                  restore_valid_r;
  word_type              restore_pc_r;
  slb_type               restore_slb_r;
  logic                  tdis_active_r;

  logic                  cand [`CAND_NUM];
  level_type             cand_lvl [`CAND_NUM];
  logic                  pick_found;
  level_type             pick_level;
  logic [3:0]            pick_idx;
  ctx_type               stack_top;
  logic                  stack_empty;
  logic                  stack_full;
  logic                  take;
  logic                  pop;
  logic                  tdis_blk;
  logic                  pin_rise;
  reg_sel_type           sel;
  logic [`USR_NUM-1:0]   user_set;

  // --------------------------------------------------------------------
  // register decode
  // --------------------------------------------------------------------
  function automatic reg_sel_type decode(input addr_type a);
    if (a <= `ADR_PRI_LAST) begin
      decode = SEL_PRI;
    end else if (a == `ADR_FLAG) begin
      decode = SEL_FLAG;
    end else if (a == `ADR_ENABLE) begin
      decode = SEL_ENABLE;
    end else if (a == `ADR_CTRL_ONE) begin
      decode = SEL_CTRL;
    end else if (a == `ADR_STATUS) begin
      decode = SEL_STATUS;
    end else begin
      decode = SEL_NONE;
    end
  endfunction : decode

  assign sel = decode(reg_addr_in);

  // --------------------------------------------------------------------
  // external pin 2 synchroniser, rising edge sets the source 0 flag
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], ext_pin2_in};
    end
  end

  assign pin_rise = pin_sync_r[1] & ~pin_sync_r[2];
  assign user_set = src_event_in | {{(`USR_NUM-1){1'b0}}, pin_rise};

  // --------------------------------------------------------------------
  // priority registers, field at bits 6-4 only
  // --------------------------------------------------------------------
  for (genvar i = 0; i < `USR_NUM; i++) begin : g_pri
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        pri_r[i] <= `PRI_RESET;
      end else if (reg_wr_in && sel == SEL_PRI
                   && reg_addr_in[2:0] == 3'(i)) begin
        pri_r[i] <= reg_wdata_in[`PRI_MSB:`PRI_LSB];
      end
    end
  end

  // --------------------------------------------------------------------
  // flags: write one to clear, a new event beats the clear
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      user_flag_r <= '0;
    end else if (reg_wr_in && sel == SEL_FLAG) begin
      user_flag_r <= (user_flag_r & ~reg_wdata_in[`USR_NUM-1:0])
                     | user_set;
    end else begin
      user_flag_r <= user_flag_r | user_set;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      en_r <= '0;
    end else if (reg_wr_in && sel == SEL_ENABLE) begin
      en_r <= reg_wdata_in[`USR_NUM-1:0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trap_flag_r <= '0;
      nest_dis_r  <= 1'b0;
    end else if (reg_wr_in && sel == SEL_CTRL) begin
      trap_flag_r <= (trap_flag_r & ~reg_wdata_in[`TRAP_MSB:0])
                     | trap_event_in;
      nest_dis_r  <= reg_wdata_in[`NEST_BIT];
    end else begin
      trap_flag_r <= trap_flag_r | trap_event_in;
    end
  end

  // --------------------------------------------------------------------
  // timed disable of levels 1-6
  // --------------------------------------------------------------------
  assign tdis_blk = (tdis_cnt_r != '0);

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tdis_cnt_r    <= '0;
      tdis_active_r <= 1'b0;
    end else if (tdis_start_in) begin
      tdis_cnt_r    <= tdis_count_in;
      tdis_active_r <= (tdis_count_in != '0);
    end else if (tdis_blk) begin
      tdis_cnt_r    <= tdis_cnt_r - 1'b1;
      tdis_active_r <= (tdis_cnt_r != `TDIS_W'(1));
    end
  end

  // --------------------------------------------------------------------
  // candidates: traps take codes 0-3, user sources follow
  // --------------------------------------------------------------------
  always_comb begin
    for (int t = 0; t < `TRAP_NUM; t++) begin
      cand_lvl[t] = `TRAP_TOP_LEVEL - 4'(t);
      // only a CPU level at or above the trap's own level holds it off
      cand[t] = trap_flag_r[t] && (cand_lvl[t] > cpu_level_r);
    end
    for (int u = 0; u < `USR_NUM; u++) begin
      cand_lvl[`TRAP_NUM+u] = {1'b0, pri_r[u]};
      cand[`TRAP_NUM+u] =
        user_flag_r[u] && en_r[u]
        && (pri_r[u] != `PRI_OFF)
        && ({1'b0, pri_r[u]} > cpu_level_r)
        && !(tdis_blk && {1'b0, pri_r[u]} < `LEVEL_USER_TOP)
        && !(nest_dis_r && !stack_empty);
    end
  end

  level_picker level_picker_i (
    .cand_in   (cand),
    .lvl_in    (cand_lvl),
    .found_out (pick_found),
    .level_out (pick_level),
    .idx_out   (pick_idx)
  );

  // --------------------------------------------------------------------
  // core handshake and level tracking
  // --------------------------------------------------------------------
  assign take = irq_ack_in && irq_req_r && !stack_full;
  assign pop  = ret_in && !stack_empty && !take;

  ctx_stack ctx_stack_i (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .push_in     (take),
    .pop_in      (pop),
    .data_in     ({pc_in, slb_in, cpu_level_r}),
    .top_out     (stack_top),
    .empty_out   (stack_empty),
    .full_out    (stack_full)
  );

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cpu_level_r <= `LEVEL_ZERO;
    end else if (take) begin
      cpu_level_r <= irq_lvl_r;
    end else if (pop) begin
      cpu_level_r <= stack_top[3:0];
    end else if (level_wr_in) begin
      cpu_level_r <= level_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      restore_valid_r <= 1'b0;
      restore_pc_r    <= `WORD_ZERO;
      restore_slb_r   <= 8'h00;
    end else begin
      restore_valid_r <= pop;
      if (pop) begin
        restore_pc_r  <= stack_top[27:12];
        restore_slb_r <= stack_top[11:4];
      end
    end
  end

  // a level change or register write makes the last pick stale, so drop
  // it one cycle: an ack then could take a source just disabled
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_req_r <= 1'b0;
      irq_vec_r <= 7'h00;
      irq_lvl_r <= `LEVEL_ZERO;
    end else begin
      irq_req_r <= pick_found && !irq_ack_in && !ret_in && !reg_wr_in
                   && !level_wr_in && !tdis_start_in;
      irq_vec_r <= pick_found ? 7'(pick_idx) : 7'h00;
      irq_lvl_r <= pick_level;
    end
  end

  // --------------------------------------------------------------------
  // register read, data stand for one cycle only
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= `WORD_ZERO;
    end else if (!reg_rd_in) begin
      rdata_r <= `WORD_ZERO;
    end else if (sel == SEL_PRI) begin
      rdata_r <= {9'h000, pri_r[reg_addr_in[2:0]], 4'h0};
    end else if (sel == SEL_FLAG) begin
      rdata_r <= {8'h00, user_flag_r};
    end else if (sel == SEL_ENABLE) begin
      rdata_r <= {8'h00, en_r};
    end else if (sel == SEL_CTRL) begin
      rdata_r <= {nest_dis_r, 11'h000, trap_flag_r};
    end else if (sel == SEL_STATUS) begin
      rdata_r <= {4'h0, cpu_level_r, 1'b0, irq_vec_r};
    end else begin
      rdata_r <= `WORD_ZERO;
    end
  end

  assign reg_rdata_out     = rdata_r;
  assign irq_req_out       = irq_req_r;
  assign irq_vector_out    = irq_vec_r;
  assign irq_level_out     = irq_lvl_r;
  assign cpu_level_out     = cpu_level_r;
  assign tdis_active_out   = tdis_active_r;
  assign restore_valid_out = restore_valid_r;
  assign restore_pc_out    = restore_pc_r;
  assign restore_slb_out   = restore_slb_r;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence quiet_s;
    !irq_ack_in && !ret_in && !level_wr_in && !tdis_start_in && !reg_wr_in;
  endsequence

  sequence ret_s;
    ret_in && !irq_ack_in && !stack_empty;
  endsequence

  user_level_a : assert property (
    irq_req_out && irq_vector_out >= `USER_CODE_BASE
    |-> irq_level_out <= `LEVEL_USER_TOP && irq_level_out != `LEVEL_ZERO)
    else $error("user grant outside levels 1-7");

  pri_reset_a : assert property (
    // second low edge: at the first the flops may not have met reset yet
    disable iff (1'b0) !rstn_in ##1 !rstn_in
      |-> pri_r[0] == `PRI_RESET && pri_r[1] == `PRI_RESET)
    else $error("priority not at reset level");

  pri_unimpl_a : assert property (
    reg_rd_in && sel == SEL_PRI
    |=> reg_rdata_out[15:7] == 9'h000 && reg_rdata_out[3:0] == 4'h0)
    else $error("unimplemented priority bits not zero");

  status_read_a : assert property (
    reg_rd_in && sel == SEL_STATUS
    |=> reg_rdata_out[`LVL_MSB:`LVL_LSB] == $past(cpu_level_r)
        && reg_rdata_out[`VEC_MSB:`VEC_LSB] == $past(irq_vec_r))
    else $error("status read does not match level and vector");

  nest_block_a : assert property (
    nest_dis_r && !stack_empty && irq_req_out
    |-> irq_level_out > `LEVEL_USER_TOP)
    else $error("user interrupt nested while disabled");

  flag_hold_a : assert property (
    user_flag_r[0] && !(reg_wr_in && sel == SEL_FLAG) |=> user_flag_r[0])
    else $error("user flag dropped without software clear");

  ret_restore_a : assert property (
    ret_s |=> restore_valid_out
              && cpu_level_out == $past(stack_top[3:0])
              && restore_pc_out == $past(stack_top[27:12]))
    else $error("return did not restore saved context");

  trap_hold_a : assert property (
    trap_flag_r[0] && !(reg_wr_in && sel == SEL_CTRL) |=> trap_flag_r[0])
    else $error("trap flag dropped without software clear");

  level7_a : assert property (
    cpu_level_out >= `LEVEL_USER_TOP && irq_req_out
    |-> irq_vector_out < `USER_CODE_BASE)
    else $error("user interrupt granted at level 7");

  trap_live_a : assert property (
    trap_flag_r[0] && cpu_level_r < `TRAP_TOP_LEVEL ##0 quiet_s
    |=> irq_req_out && irq_level_out == `TRAP_TOP_LEVEL)
    else $error("top trap not presented");

  tdis_mask_a : assert property (
    tdis_active_out && irq_req_out
    |-> irq_level_out >= `LEVEL_USER_TOP)
    else $error("level 1-6 granted during timed disable");
endmodule : intc_core

`default_nettype wire

// ==== sim/core_model.sv ====
// Purpose: processor core side, takes presented interrupts
// Assumes: one clock, ack is a one-cycle pulse
// Notes:   acks only while ack_en_in is high
`default_nettype none

module core_model (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ack_en_in,
  input  wire logic        req_in,
  output logic             ack_out,
  output logic [15:0]      pc_out,
  output logic [7:0]       slb_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] saved_pc;
  logic [7:0]  saved_slb;

  assign slb_out = pc_out[8:1];

  // pc runs free so a stale restore shows up
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_out  <= 16'h1000;
      ack_out <= 1'b0;
    end else begin
      pc_out  <= pc_out + 16'h0002;
      ack_out <= ack_en_in && req_in && !ack_out;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ack_out && req_in) begin
      saved_pc  <= pc_out;
      saved_slb <= slb_out;
    end
  end
endmodule : core_model

`default_nettype wire

// ==== sim/test_interrupt_priority_controller.sv ====
// Purpose: self-checking bench of the interrupt priority controller
// Assumes: core_model answers the core handshake
// Notes:   every scenario is a task that judges its own result
`default_nettype none
`include "intc_map.svh"

module test_interrupt_priority_controller;
  import intc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, wr_s = 1'b0, rd_s = 1'b0, ext = 1'b0;
  logic ret = 1'b0, lvl_wr = 1'b0, dstart = 1'b0, ack_en = 1'b0;
  addr_type addr = '0;
  word_type wdata = '0, rdata, rpc, pc;
  logic [7:0] src_ev = '0, slb, rslb;
  logic [3:0] trap_ev = '0;
  level_type lvl_in = '0, lvl, cpu;
  logic [13:0] dcount = '0;
  logic ack, req, dact, rv;
  vec_code_type vec;
  int n_errors = 0, tests_run = 0;

  initial forever #20 clk = ~clk;

  intc_core intc_core_i (.core_clk_in(clk), .rstn_in(rstn),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_rdata_out(rdata), .src_event_in(src_ev),
    .ext_pin2_in(ext), .trap_event_in(trap_ev), .irq_ack_in(ack),
    .pc_in(pc), .slb_in(slb), .ret_in(ret), .level_wr_in(lvl_wr),
    .level_in(lvl_in), .tdis_start_in(dstart), .tdis_count_in(dcount),
    .irq_req_out(req), .irq_vector_out(vec), .irq_level_out(lvl),
    .cpu_level_out(cpu), .tdis_active_out(dact),
    .restore_valid_out(rv), .restore_pc_out(rpc),
    .restore_slb_out(rslb));

  core_model core_model_i (.clk_in(clk), .rstn_in(rstn),
    .ack_en_in(ack_en), .req_in(req), .ack_out(ack), .pc_out(pc),
    .slb_out(slb));

  // ----------
  // helpers
  // ----------
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input word_type e, input word_type g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input addr_type a, input word_type d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  task automatic rd(input addr_type a, input word_type e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk("read data", e, rdata);
  endtask : rd

  task automatic ev(input logic [7:0] u, input logic [3:0] t);
    @(posedge clk);
    src_ev  <= u;
    trap_ev <= t;
    @(posedge clk);
    src_ev  <= '0;
    trap_ev <= '0;
  endtask : ev

  // k: 0 return, 1 level write, 2 timed disable
  task automatic ctl(input int k, input logic [13:0] v);
    @(posedge clk);
    ret    <= (k == 0);
    lvl_wr <= (k == 1);
    dstart <= (k == 2);
    lvl_in <= v[3:0];
    dcount <= v;
    @(posedge clk);
    ret    <= 1'b0;
    lvl_wr <= 1'b0;
    dstart <= 1'b0;
    #1;
  endtask : ctl

  task automatic ack_one;
    @(posedge clk);
    ack_en <= 1'b1;
    cyc(3);
    @(posedge clk);
    ack_en <= 1'b0;
  endtask : ack_one

  task automatic wait_req(input vec_code_type v, input level_type l);
    for (int i = 0; i < 40 && req !== 1'b1; i++) cyc(1);
    chk("request", 1, req);
    chk("vector", v, vec);
    chk("level", l, lvl);
    if (req !== 1'b1) finish_test();
  endtask : wait_req

  task automatic no_req;
    cyc(6);
    chk("request", 0, req);
  endtask : no_req

  task automatic tidy;
    wr(`ADR_FLAG, 16'h00ff);
    wr(`ADR_ENABLE, 16'h0000);
    for (int a = 0; a < 8; a++) wr(addr_type'(a), 16'h0040);
    no_req();
  endtask : tidy

  // ----------
  // scenarios
  // ----------
  task automatic t_reset;
    rd(`ADR_PRI_EXT2, 16'h0040);
    rd(`ADR_PRI_SERR, 16'h0040);
    wr(`ADR_STATUS, 16'hffff);
    rd(`ADR_STATUS, 16'h0000);
    rd(5'h0c, 16'h0000);
  endtask : t_reset

  task automatic t_fields;
    wr(`ADR_PRI_EXT2, 16'hffff);
    rd(`ADR_PRI_EXT2, 16'h0070);
    wr(`ADR_PRI_SERR, 16'hff8f);
    rd(`ADR_PRI_SERR, 16'h0000);
    wr(`ADR_PRI_EXT2, 16'h0000);
    wr(`ADR_ENABLE, 16'h0003);
    @(posedge clk);
    ext <= 1'b1;
    ev(8'h02, 4'h0);
    no_req();
    wr(`ADR_PRI_EXT2, 16'h0040);
    wait_req(7'h04, 4'h4);
    @(posedge clk);
    ext <= 1'b0;
    tidy();
  endtask : t_fields

  task automatic t_service;
    wr(`ADR_ENABLE, 16'h0008);
    ev(8'h08, 4'h0);
    wait_req(7'h07, 4'h4);
    rd(`ADR_STATUS, 16'h0007);
    ack_one();
    chk("cpu level", 4, cpu);
    rd(`ADR_STATUS, 16'h0400);
    ctl(0, 0);
    chk("restore valid", 1, rv);
    chk("restore pc", core_model_i.saved_pc, rpc);
    chk("restore status byte", core_model_i.saved_slb, rslb);
    chk("cpu level", 0, cpu);
    wait_req(7'h07, 4'h4);
    tidy();
  endtask : t_service

  task automatic t_order;
    wr(`ADR_ENABLE, 16'h0024);
    ev(8'h24, 4'h0);
    wait_req(7'h06, 4'h4);
    wr(5'h05, 16'h0070);
    cyc(3);
    wait_req(7'h09, 4'h7);
    wr(5'h05, 16'h0010);
    wr(5'h02, 16'h0000);
    cyc(3);
    wait_req(7'h09, 4'h1);
    tidy();
  endtask : t_order

  task automatic t_mask;
    wr(5'h05, 16'h0070);
    wr(`ADR_ENABLE, 16'h0020);
    ctl(1, 7);
    chk("cpu level", 7, cpu);
    ev(8'h20, 4'h0);
    no_req();
    ev(8'h00, 4'h2);
    wait_req(7'h01, 4'he);
    cyc(10);
    chk("request", 1, req);
    wr(`ADR_CTRL_ONE, 16'h0002);
    no_req();
    ctl(1, 0);
    wait_req(7'h09, 4'h7);
    tidy();
  endtask : t_mask

  task automatic t_nest;
    wr(`ADR_CTRL_ONE, 16'h8000);
    rd(`ADR_CTRL_ONE, 16'h8000);
    wr(5'h05, 16'h0070);
    wr(`ADR_ENABLE, 16'h0028);
    ev(8'h08, 4'h0);
    wait_req(7'h07, 4'h4);
    ack_one();
    ev(8'h20, 4'h0);
    no_req();
    ev(8'h00, 4'h1);
    wait_req(7'h00, 4'hf);
    wr(`ADR_CTRL_ONE, 16'h0001);
    ctl(0, 0);
    tidy();
  endtask : t_nest

  task automatic t_timed_interrupt_disable;
    wr(5'h05, 16'h0070);
    wr(`ADR_ENABLE, 16'h0028);
    ctl(2, 14'd60);
    chk("disable active", 1, dact);
    ev(8'h08, 4'h0);
    no_req();
    ev(8'h20, 4'h0);
    wait_req(7'h09, 4'h7);
    wr(`ADR_FLAG, 16'h0020);
    for (int i = 0; i < 100 && dact !== 1'b0; i++) cyc(1);
    chk("disable active", 0, dact);
    wait_req(7'h07, 4'h4);
    tidy();
  endtask : t_timed_interrupt_disable

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    cyc(2);
    t_reset();
    t_fields();
    t_service();
    t_order();
    t_mask();
    t_nest();
    t_timed_interrupt_disable();
    finish_test();
  end
endmodule : test_interrupt_priority_controller

`default_nettype wire
